/* verilog/irpwm_timer_pair.sv */
// 16-bit five-channel PWM/capture timer with two 8-bit companions and IR mode
// Assumes APB master on sys_clk; pin inputs synchronous to sys_clk
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "irpwm_params.svh"
// Functional notes
// - 16-bit counter, prescaler, programmable period wrap
// - Five channels, each with 16-bit compare
// - Channel selects PWM output or capture
// - IR mode counts companion timer periods
// - IR output is main AND companion
// - Companion: prescaled 8-bit counter, 8-bit period
// - Companion single channel usable as PWM
module irpwm_timer_pair import irpwm_pkg::*; #(
  parameter int NCH = `IRPWM_NCH
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [NCH-1:0]  capIn,
  output logic      [NCH-1:0]  pwmOut,
  output logic                 smallAPwm,
  output logic                 smallBPwm,
  output logic                 irOut,
  output logic                 irq
);
  typedef struct packed {
    logic [1:0]             ctrl;
    logic [15:0]            presc;
    logic [15:0]            period;
    logic [15:0]            pre;
    logic [15:0]            cnt;
    logic [2*NCH-1:0]       chMode;
    logic [NCH*16-1:0]      cc;
    logic [NCH-1:0]         capPrev;
    logic [NCH:0]           status;
    logic [NCH:0]           mask;
    logic [NCH-1:0]         pwm;
    logic [2:0][7:0]        aCfg;
    logic                   aRun;
    logic [2:0][7:0]        bCfg;
    logic                   bRun;
    logic                   ir;
    logic                   irqQ;
    logic                   aPwm;
    logic                   bPwm;
    logic [31:0]            rdata;
    logic                   ready;
    logic                   err;
  } irpwm_state_t;
  irpwm_state_t st;
  irpwm_state_t next_st;

  irpwm_small_if aIf ();
  irpwm_small_if bIf ();

  assign aIf.run      = st.aRun;
  assign aIf.prescale = st.aCfg[0];
  assign aIf.period   = st.aCfg[1];
  assign aIf.compare  = st.aCfg[2];
  assign bIf.run      = st.bRun;
  assign bIf.prescale = st.bCfg[0];
  assign bIf.period   = st.bCfg[1];
  assign bIf.compare  = st.bCfg[2];

  irpwm_small_timer uSmallA (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bus     (aIf.tmr)
  );
  irpwm_small_timer uSmallB (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bus     (bIf.tmr)
  );

  // Channel index for an address in the compare block, or NCH when none
  function automatic int chIndex(input logic [11:0] a);
    int k;
    chIndex = NCH;
    for (k = 0; k < NCH; k++) begin
      if (a == `IRPWM_OFF_CC0 + 12'(4 * k)) begin
        chIndex = k;
      end
    end
  endfunction

  // Companion register slot 0..3 at base, or 4 when none
  function automatic logic [2:0] smallSlot(input logic [11:0] a, input logic [11:0] base);
    smallSlot = 3'h4;
    if (a[11:4] == base[11:4] && a[1:0] == 2'h0) begin
      smallSlot = {1'b0, a[3:2]};
    end
  endfunction

  logic setup;
  logic access;
  assign setup  = psel && !penable;
  assign access = psel && penable && st.ready;

  always_comb begin
    int ci;
    logic [2:0] sa;
    logic [2:0] sb;
    logic tick;
    logic [NCH:0] events;
    irpwm_chmode_t m;
    ci = chIndex(paddr);
    sa = smallSlot(paddr, `IRPWM_OFF_A_CTRL);
    sb = smallSlot(paddr, `IRPWM_OFF_B_CTRL);
    tick = 1'b0;
    events = '0;
    m = IRPWM_CH_OFF;
    next_st = st;

    // tick source: prescaler or companion wrap
    if (st.ctrl[`IRPWM_BIT_IRMODE]) begin
      tick = aIf.wrapPulse;
    end else if (st.pre >= st.presc) begin
      tick = 1'b1;
    end
    if (st.ctrl[`IRPWM_BIT_RUN]) begin
      next_st.pre = (st.pre >= st.presc) ? 16'h0000 : st.pre + 16'h0001;
      if (tick) begin
        if (st.cnt >= st.period) begin
          next_st.cnt = 16'h0000;
          events[NCH] = 1'b1;
        end else begin
          next_st.cnt = st.cnt + 16'h0001;
        end
      end
    end

    for (int k = 0; k < NCH; k++) begin
      m = irpwm_chmode_t'(st.chMode[2*k +: 2]);
      next_st.capPrev[k] = capIn[k];
      next_st.pwm[k] = (m == IRPWM_CH_PWM) && st.ctrl[`IRPWM_BIT_RUN] &&
                       (next_st.cnt < st.cc[16*k +: 16]);
      if ((m == IRPWM_CH_CAPRISE && capIn[k] && !st.capPrev[k]) ||
          (m == IRPWM_CH_CAPFALL && !capIn[k] && st.capPrev[k])) begin
        next_st.cc[16*k +: 16] = st.cnt;
        events[k] = 1'b1;
      end
    end

    next_st.ir   = st.ctrl[`IRPWM_BIT_IRMODE] && next_st.pwm[0] && aIf.pwmOut;
    next_st.aPwm = aIf.pwmOut;
    next_st.bPwm = bIf.pwmOut;

    // APB: no wait state, answer in the first access cycle after setup
    next_st.ready = setup;
    next_st.err   = 1'b0;
    next_st.rdata = 32'h0000_0000;
    if (setup) begin
      next_st.err = 1'b1;
      case (paddr)
        `IRPWM_OFF_CTRL:   begin next_st.rdata = 32'(st.ctrl);   next_st.err = 1'b0; end
        `IRPWM_OFF_PRESC:  begin next_st.rdata = 32'(st.presc);  next_st.err = 1'b0; end
        `IRPWM_OFF_PERIOD: begin next_st.rdata = 32'(st.period); next_st.err = 1'b0; end
        `IRPWM_OFF_COUNT:  begin next_st.rdata = 32'(st.cnt);    next_st.err = 1'b0; end
        `IRPWM_OFF_CHMODE: begin next_st.rdata = 32'(st.chMode); next_st.err = 1'b0; end
        `IRPWM_OFF_STATUS: begin next_st.rdata = 32'(st.status); next_st.err = 1'b0; end
        `IRPWM_OFF_MASK:   begin next_st.rdata = 32'(st.mask);   next_st.err = 1'b0; end
        default: begin
          if (ci < NCH) begin
            next_st.rdata = 32'(st.cc[16*ci +: 16]);
            next_st.err = 1'b0;
          end else if (sa < 3'h4) begin
            next_st.rdata = (sa == 3'h3) ? 32'(st.aRun) :
                            (sa == 3'h2) ? 32'(aIf.count) : 32'(st.aCfg[sa[1:0]]);
            next_st.err = 1'b0;
          end else if (sb < 3'h4) begin
            next_st.rdata = (sb == 3'h3) ? 32'(st.bRun) :
                            (sb == 3'h2) ? 32'(bIf.count) : 32'(st.bCfg[sb[1:0]]);
            next_st.err = 1'b0;
          end
        end
      endcase
    end else if (access) begin
      next_st.rdata = st.rdata;
      next_st.err   = st.err;
    end

    // Status write-one-to-clear; a same-cycle event wins
    next_st.status = st.status;
    if (access && pwrite && !st.err) begin
      case (paddr)
        `IRPWM_OFF_CTRL:   next_st.ctrl   = pwdata[1:0];
        `IRPWM_OFF_PRESC:  next_st.presc  = pwdata[15:0];
        `IRPWM_OFF_PERIOD: next_st.period = pwdata[15:0];
        `IRPWM_OFF_COUNT:  next_st.cnt    = pwdata[15:0];
        `IRPWM_OFF_CHMODE: next_st.chMode = pwdata[2*NCH-1:0];
        `IRPWM_OFF_STATUS: next_st.status = st.status & ~pwdata[NCH:0];
        `IRPWM_OFF_MASK:   next_st.mask   = pwdata[NCH:0];
        default: begin
          if (ci < NCH) begin
            next_st.cc[16*ci +: 16] = pwdata[15:0];
          end else if (sa == 3'h3) begin
            next_st.aRun = pwdata[0];
          end else if (sa < 3'h2) begin
            next_st.aCfg[sa[1:0]] = pwdata[7:0];
          end else if (sa == 3'h2) begin
            next_st.aCfg[2] = pwdata[7:0];
          end else if (sb == 3'h3) begin
            next_st.bRun = pwdata[0];
          end else if (sb < 3'h4) begin
            next_st.bCfg[sb[1:0]] = pwdata[7:0];
          end
        end
      endcase
    end
    next_st.status = next_st.status | events;
    next_st.irqQ = |(next_st.status & st.mask);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.period <= `IRPWM_RST_PERIOD;
      st.aCfg   <= {`IRPWM_RST_8PERIOD, `IRPWM_RST_8PERIOD, 8'h00};
      st.bCfg   <= {`IRPWM_RST_8PERIOD, `IRPWM_RST_8PERIOD, 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign prdata    = st.rdata;
  assign pready    = st.ready;
  assign pslverr   = st.err;
  assign pwmOut    = st.pwm;
  assign smallAPwm = st.aPwm;
  assign smallBPwm = st.bPwm;
  assign irOut     = st.ir;
  assign irq       = st.irqQ;

  // count never exceeds period after tick
  a_cnt_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.ctrl[`IRPWM_BIT_RUN] && !st.ctrl[`IRPWM_BIT_IRMODE] && st.cnt == st.period && st.pre >= st.presc
    && !(access && pwrite) |=> st.cnt == 16'h0000)
    else $error("main counter did not wrap at period");
  a_cc_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    access && pwrite && paddr == `IRPWM_OFF_CC0 && st.chMode[1:0] != 2'h2 && st.chMode[1:0] != 2'h3
    |=> st.cc[15:0] == $past(pwdata[15:0]))
    else $error("channel 0 compare not stored");
  a_ch_off_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(st.chMode[1:0]) != 2'h1 |-> !pwmOut[0])
    else $error("pwm driven while channel not in pwm mode");
  // IR mode only counts on companion wrap
  a_ir_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.ctrl == 2'h3 && !aIf.wrapPulse && !(access && pwrite) |=> $stable(st.cnt))
    else $error("counter moved without companion period in ir mode");
  // IR output needs companion PWM in IR mode
  a_ir_and: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irOut |-> $past(aIf.pwmOut) && $past(st.ctrl[`IRPWM_BIT_IRMODE]))
    else $error("ir output high without companion pwm");
  a_cap_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.chMode[1:0] == 2'h2 && capIn[0] && !st.capPrev[0] && !(access && pwrite)
    |=> st.cc[15:0] == $past(st.cnt) && st.status[0])
    else $error("capture edge not latched");
  // Interrupt follows masked status
  // A W1C or mask write in the same cycle may lower the interrupt legally
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(st.status & st.mask) && !(access && pwrite) |=> ##[0:1] irq)
    else $error("interrupt missing for masked status");
endmodule // irpwm_timer_pair

/* shared/irpwm_params.svh */
// Register offsets, field positions and reset values for the IR/PWM timer pair
// Assumes APB byte addressing with one 32-bit word per register
`ifndef IRPWM_PARAMS_SVH
`define IRPWM_PARAMS_SVH
`define IRPWM_OFF_CTRL    12'h000
`define IRPWM_OFF_PRESC   12'h004
`define IRPWM_OFF_PERIOD  12'h008
`define IRPWM_OFF_COUNT   12'h00C
`define IRPWM_OFF_CHMODE  12'h010
`define IRPWM_OFF_STATUS  12'h014
`define IRPWM_OFF_MASK    12'h018
`define IRPWM_OFF_CC0     12'h020
`define IRPWM_OFF_A_CTRL  12'h040
`define IRPWM_OFF_B_CTRL  12'h050
`define IRPWM_BIT_RUN     0
`define IRPWM_BIT_IRMODE  1
`define IRPWM_RST_PERIOD  16'hFFFF
`define IRPWM_RST_8PERIOD 8'hFF
`define IRPWM_NCH         5
`endif

/* shared/irpwm_pkg.sv */
// Types shared by the IR/PWM timer pair
// Assumes the params header is compiled alongside
package irpwm_pkg;
  typedef enum logic [1:0] {
    IRPWM_CH_OFF     = 2'h0,
    IRPWM_CH_PWM     = 2'h1,
    IRPWM_CH_CAPRISE = 2'h2,
    IRPWM_CH_CAPFALL = 2'h3
  } irpwm_chmode_t;
endpackage

/* shared/irpwm_small_if.sv */
// Connection between main timer and an 8-bit companion timer
// Assumes one clock domain
`timescale 1ns/1ps
interface irpwm_small_if;
  logic       run;
  logic [7:0] prescale;
  logic [7:0] period;
  logic [7:0] compare;
  logic       wrapPulse;
  logic       pwmOut;
  logic [7:0] count;
  modport ctl (output run, prescale, period, compare, input wrapPulse, pwmOut, count);
  modport tmr (input run, prescale, period, compare, output wrapPulse, pwmOut, count);
endinterface

/* verilog/irpwm_small_timer.sv */
// 8-bit companion timer with prescaler, period and one PWM channel
// Assumes settings held by the parent, synchronous to sys_clk
`timescale 1ns/1ps
module irpwm_small_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  irpwm_small_if.tmr bus
);
  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] cnt;
    logic       wrap;
    logic       pwm;
  } irpwm_st_t;
  irpwm_st_t st;
  irpwm_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.wrap = 1'b0;
    if (bus.run) begin
      if (st.pre >= bus.prescale) begin
        next_st.pre = 8'h00;
        if (st.cnt >= bus.period) begin
          next_st.cnt = 8'h00;
          next_st.wrap = 1'b1;
        end else begin
          next_st.cnt = st.cnt + 8'h01;
        end
      end else begin
        next_st.pre = st.pre + 8'h01;
      end
    end
    next_st.pwm = bus.run && (next_st.cnt < bus.compare);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.wrapPulse = st.wrap;
  assign bus.pwmOut    = st.pwm;
  assign bus.count     = st.cnt;

  a_small_pwm_cmp: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus.run && $stable(bus.compare) && $stable(bus.run) |-> st.pwm == (st.cnt < bus.compare))
    else $error("small timer pwm mismatch");
  a_small_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.wrap |-> st.cnt == 8'h00)
    else $error("small timer wrap without zero count");
endmodule // irpwm_small_timer

/* test/irpwm_pin_model.sv */
// Pin-side model: drives capture inputs, tallies high cycles of outputs
// Assumes every pin is synchronous to sys_clk
`timescale 1ns/1ps
module irpwm_pin_model (
  input  wire logic             sys_clk,
  input  wire logic [4:0]       pinSet,
  input  wire logic             clr,
  input  wire logic [7:0]       pins,
  output logic      [4:0]       capIn,
  output logic      [7:0][15:0] highCnt
);
  // Pins change only after an edge, as a synchronous source would
  always @(posedge sys_clk) begin
    capIn <= pinSet;
    for (int i = 0; i < 8; i++) begin
      highCnt[i] <= clr ? 16'h0000 : highCnt[i] + {15'h0000, pins[i]};
    end
  end
endmodule // irpwm_pin_model

/* test/irpwm_timer_pair_test.sv */
// Self-checking bench for the IR/PWM timer pair
// Assumes the pin model and the params header
`timescale 1ns/1ps
`include "irpwm_params.svh"
module irpwm_timer_pair_test;
  logic             sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irOut, irq, errv, clr;
  logic             smallAPwm, smallBPwm;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rdv, v, seed;
  logic [4:0]       capIn, pwmOut, pinSet;
  logic [7:0][15:0] highCnt;
  logic [7:0][31:0] cmp;
  int               errors, checks;

  irpwm_timer_pair DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .capIn(capIn),
    .pwmOut(pwmOut), .smallAPwm(smallAPwm), .smallBPwm(smallBPwm), .irOut(irOut), .irq(irq));
  irpwm_pin_model pins_i (.sys_clk(sys_clk), .pinSet(pinSet), .clr(clr),
    .pins({irOut, smallBPwm, smallAPwm, pwmOut}), .capIn(capIn), .highCnt(highCnt));

  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Model: high cycles over whole periods
  function automatic int duty(int n, int c, int per);
    return n * c / (per + 1);
  endfunction

  task report_and_stop();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rdv = prdata;
    errv = pslverr;
    if (n >= 16) begin
      errors++;
      report_and_stop();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask

  task measure(input int n);
    clr <= 1'h1;
    @(posedge sys_clk);
    clr <= 1'h0;
    repeat (n + 1) @(posedge sys_clk);
  endtask

  initial begin
    rst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h000; pwdata = 32'h0;
    pinSet = 5'h00; clr = 1'h1; seed = 32'h50DF92E8; errors = 0; checks = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'h1;
    apb(1'h0, `IRPWM_OFF_PERIOD, 32'h0); chk(rdv, 32'h0000FFFF);
    apb(1'h0, `IRPWM_OFF_A_CTRL + 12'h004, 32'h0); chk(rdv, 32'h000000FF);
    apb(1'h1, 12'hFFC, rnd()); chk({31'h0, errv}, 32'h1);
    apb(1'h0, 12'hFFC, 32'h0); chk(rdv, 32'h0);
    v = rnd() & 32'h0000FFFF;
    apb(1'h1, `IRPWM_OFF_COUNT, v);
    apb(1'h0, `IRPWM_OFF_COUNT, 32'h0); chk(rdv, v);
    // Stopped counter makes the captured value exact
    apb(1'h1, `IRPWM_OFF_CHMODE, 32'h0000003A);
    pinSet <= 5'h07;
    repeat (6) @(posedge sys_clk);
    pinSet <= 5'h03;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, `IRPWM_OFF_CC0 + 12'(4 * i), 32'h0); chk(rdv, v);
    end
    apb(1'h0, `IRPWM_OFF_STATUS, 32'h0); chk(rdv, 32'h00000007);
    apb(1'h1, `IRPWM_OFF_STATUS, 32'h0000003F);
    apb(1'h0, `IRPWM_OFF_STATUS, 32'h0); chk(rdv, 32'h0);
    pinSet <= 5'h00;
    apb(1'h1, `IRPWM_OFF_CHMODE, 32'h00000155);
    apb(1'h1, `IRPWM_OFF_PRESC, 32'h1);
    apb(1'h1, `IRPWM_OFF_PERIOD, 32'h3);
    for (int i = 0; i < 5; i++) begin
      cmp[i] = rnd() % 5;
      apb(1'h1, `IRPWM_OFF_CC0 + 12'(4 * i), cmp[i]);
    end
    apb(1'h1, `IRPWM_OFF_MASK, 32'h0);
    apb(1'h1, `IRPWM_OFF_CTRL, 32'h1);
    measure(80);
    for (int i = 0; i < 5; i++) begin
      chk({16'h0, highCnt[i]}, 32'(duty(80, cmp[i], 3)));
    end
    apb(1'h0, `IRPWM_OFF_STATUS, 32'h0); chk(rdv & 32'h20, 32'h20);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, `IRPWM_OFF_MASK, 32'h20);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, `IRPWM_OFF_CTRL, 32'h0);
    apb(1'h1, `IRPWM_OFF_STATUS, 32'h20);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    for (int t = 0; t < 2; t++) begin
      cmp[5 + t] = rnd() % 5;
      apb(1'h1, `IRPWM_OFF_A_CTRL + 12'(16 * t), 32'h1);
      apb(1'h1, `IRPWM_OFF_A_CTRL + 12'(16 * t) + 12'h004, 32'h3);
      apb(1'h1, `IRPWM_OFF_A_CTRL + 12'(16 * t) + 12'h008, cmp[5 + t]);
      apb(1'h1, `IRPWM_OFF_A_CTRL + 12'(16 * t) + 12'h00C, 32'h1);
      measure(80);
      chk({16'h0, highCnt[5 + t]}, 32'(duty(80, cmp[5 + t], 3)));
    end
    // Companion period of five clocks tells it apart from the main prescaler
    apb(1'h1, `IRPWM_OFF_A_CTRL, 32'h0);
    apb(1'h1, `IRPWM_OFF_A_CTRL + 12'h004, 32'h4);
    apb(1'h1, `IRPWM_OFF_A_CTRL + 12'h008, 32'h2);
    apb(1'h1, `IRPWM_OFF_COUNT, 32'h0);
    apb(1'h1, `IRPWM_OFF_PERIOD, 32'h1);
    apb(1'h1, `IRPWM_OFF_CC0, 32'h1);
    apb(1'h1, `IRPWM_OFF_CTRL, 32'h3);
    measure(100);
    chk({16'h0, highCnt[0]}, 32'(duty(100, 1, 1)));
    chk({16'h0, highCnt[7]}, 32'(duty(duty(100, 1, 1), 2, 4)));
    report_and_stop();
  end
endmodule // irpwm_timer_pair_test
